// [frt_pkg.sv]
// Package for the free-running capture/compare timer: offsets, fields, resets.
// Assumes an 8-bit CPU bus with byte addresses in the 0xFF90 page.
package frt_pkg;
  localparam logic [15:0] ADDR_CTRL = 16'hFF90;
  localparam logic [15:0] ADDR_STAT = 16'hFF91;
  localparam logic [15:0] ADDR_CNT_HI = 16'hFF92;
  localparam logic [15:0] ADDR_CNT_LO = 16'hFF93;
  localparam logic [15:0] ADDR_CMPA_HI = 16'hFF94;
  localparam logic [15:0] ADDR_CMPA_LO = 16'hFF95;
  localparam logic [15:0] ADDR_CMPB_HI = 16'hFF96;
  localparam logic [15:0] ADDR_CMPB_LO = 16'hFF97;
  localparam logic [15:0] ADDR_CAP_HI = 16'hFF98;
  localparam logic [15:0] ADDR_CAP_LO = 16'hFF99;
  localparam int CTRL_CAP_IE = 7;
  localparam int CTRL_CMPB_IE = 6;
  localparam int CTRL_CMPA_IE = 5;
  localparam int CTRL_WRAP_IE = 4;
  localparam int CTRL_PINB_EN = 3;
  localparam int CTRL_PINA_EN = 2;
  localparam int STAT_CAP_F = 7;
  localparam int STAT_CMPB_F = 6;
  localparam int STAT_CMPA_F = 5;
  localparam int STAT_WRAP_F = 4;
  localparam int STAT_LVL_B = 3;
  localparam int STAT_LVL_A = 2;
  localparam int STAT_EDGE = 1;
  localparam int STAT_CLR_A = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'hFFFF;
  localparam logic [15:0] CAP_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [4:0] DIV2_MASK = 5'h01;
  localparam logic [4:0] DIV8_MASK = 5'h07;
  localparam logic [4:0] DIV32_MASK = 5'h1F;
  localparam logic [1:0] CKS_DIV2 = 2'h0;
  localparam logic [1:0] CKS_DIV8 = 2'h1;
  localparam logic [1:0] CKS_DIV32 = 2'h2;
  localparam logic [1:0] CKS_EXT = 2'h3;
endpackage

// [frt_pin_if.sv]
// Interface carrying the edge pulses of the synchronised pins; no pin levels.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface frt_pin_if;
  logic ext_rise;
  logic cap_rise;
  logic cap_fall;
  modport src (output ext_rise, output cap_rise, output cap_fall);
  modport dst (input ext_rise, input cap_rise, input cap_fall);
endinterface
`default_nettype wire

// [frt_pin_sync.sv]
// Three-stage synchronisers and edge detectors for the two timer input pins.
// Assumes pins are asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module frt_pin_sync (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic external_count_clock_pin,
  input wire logic capture_input_pin,
  frt_pin_if.src pins
);
  logic [2:0] ext_sync_reg;
  logic [2:0] cap_sync_reg;
  logic ext_lvl_reg;
  logic cap_lvl_reg;
  logic [3:0] warm_reg;
  logic ready;

  // Edges are ignored until the stages hold real pin levels after reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      warm_reg <= 4'h0;
    end else begin
      warm_reg <= {warm_reg[2:0], 1'b1};
    end
  end

  assign ready = warm_reg[3];

  // Synchronise both pins; a change counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ext_sync_reg <= 3'h0;
      cap_sync_reg <= 3'h0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], external_count_clock_pin};
      cap_sync_reg <= {cap_sync_reg[1:0], capture_input_pin};
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ext_lvl_reg <= 1'b0;
      cap_lvl_reg <= 1'b0;
    end else begin
      if (!ready || (ext_sync_reg[1] == ext_sync_reg[2])) begin
        ext_lvl_reg <= ext_sync_reg[2];
      end
      if (!ready || (cap_sync_reg[1] == cap_sync_reg[2])) begin
        cap_lvl_reg <= cap_sync_reg[2];
      end
    end
  end

  assign pins.ext_rise = ready && (ext_sync_reg[1] == ext_sync_reg[2]) &&
                         ext_sync_reg[2] && !ext_lvl_reg;
  assign pins.cap_rise = ready && (cap_sync_reg[1] == cap_sync_reg[2]) &&
                         cap_sync_reg[2] && !cap_lvl_reg;
  assign pins.cap_fall = ready && (cap_sync_reg[1] == cap_sync_reg[2]) &&
                         !cap_sync_reg[2] && cap_lvl_reg;
endmodule
`default_nettype wire

// [frt_timer.sv]
// Free-running 16-bit capture/compare timer with 8-bit CPU register port.
// Assumes single-cycle CPU byte accesses on sys_clk; standby drives reset.
`timescale 1ns/1ps
`default_nettype none
module frt_timer
  import frt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic external_count_clock_pin,
  input wire logic capture_input_pin,
  output logic compare_pin_a,
  output logic compare_pin_b,
  output logic capture_irq,
  output logic compare_a_irq,
  output logic compare_b_irq,
  output logic wrap_irq,
  output logic [2:0] irq_top_code
);
  import frt_pkg::*;

  frt_pin_if pins ();

  frt_pin_sync u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .external_count_clock_pin(external_count_clock_pin),
    .capture_input_pin(capture_input_pin),
    .pins(pins)
  );

  logic [7:0] timer_control_reg;
  logic [7:0] timer_ctrl_status_reg;
  logic [15:0] free_running_counter_reg;
  logic [15:0] compare_value_a_reg;
  logic [15:0] compare_value_b_reg;
  logic [15:0] capture_value_reg;
  logic [7:0] byte_staging_latch_reg;
  logic [3:0] flag_seen_reg;
  logic [4:0] prescale_reg;
  logic cap_pend_reg;
  logic pin_a_reg;
  logic pin_b_reg;
  logic [7:0] rdata_reg;

  logic tick;
  logic wr_cnt_lo;
  logic wr_cmpa_lo;
  logic wr_cmpb_lo;
  logic match_a;
  logic match_b;
  logic clear_a;
  logic wrap_ev;
  logic cap_edge;
  logic cap_hi_read;
  logic cap_strobe;
  logic stat_wr;
  logic stat_rd;
  logic [3:0] flag_set;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction

  // Prescaler taps: one tick per cycle of the selected source
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prescale_reg <= 5'h00;
    end else begin
      prescale_reg <= prescale_reg + 5'h01;
    end
  end

  always_comb begin
    case (timer_control_reg[1:0])
      CKS_DIV2: tick = (prescale_reg & DIV2_MASK) == DIV2_MASK;
      CKS_DIV8: tick = (prescale_reg & DIV8_MASK) == DIV8_MASK;
      CKS_DIV32: tick = (prescale_reg & DIV32_MASK) == DIV32_MASK;
      default: tick = pins.ext_rise;
    endcase
  end

  assign wr_cnt_lo = bus_wr && hit(bus_addr, ADDR_CNT_LO);
  assign wr_cmpa_lo = bus_wr && hit(bus_addr, ADDR_CMPA_LO);
  assign wr_cmpb_lo = bus_wr && hit(bus_addr, ADDR_CMPB_LO);
  assign stat_wr = bus_wr && hit(bus_addr, ADDR_STAT);
  assign stat_rd = bus_rd && hit(bus_addr, ADDR_STAT);
  assign cap_hi_read = bus_rd && hit(bus_addr, ADDR_CAP_HI);

  // Each compare match is inhibited during a lower-byte write to its own compare register
  assign match_a = hit(free_running_counter_reg, compare_value_a_reg) &&
                   !wr_cmpa_lo;
  assign match_b = hit(free_running_counter_reg, compare_value_b_reg) &&
                   !wr_cmpb_lo;
  assign clear_a = match_a && timer_ctrl_status_reg[STAT_CLR_A];
  assign wrap_ev = tick && !clear_a && !wr_cnt_lo &&
                   hit(free_running_counter_reg, CNT_MAX);

  // Capture edge selection and one-cycle hold-off behind an upper read
  assign cap_edge = timer_ctrl_status_reg[STAT_EDGE] ? pins.cap_rise :
                    pins.cap_fall;
  assign cap_strobe = (cap_edge || cap_pend_reg) && !cap_hi_read;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cap_pend_reg <= 1'b0;
    end else begin
      cap_pend_reg <= (cap_edge || cap_pend_reg) && cap_hi_read;
    end
  end

  // Counter: clear beats write, write beats increment
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      free_running_counter_reg <= CNT_RESET;
    end else if (clear_a) begin
      free_running_counter_reg <= CNT_RESET;
    end else if (wr_cnt_lo) begin
      free_running_counter_reg <= {byte_staging_latch_reg, bus_wdata};
    end else if (tick) begin
      free_running_counter_reg <= free_running_counter_reg + 16'h0001;
    end
  end

  // Compare registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      compare_value_a_reg <= CMP_RESET;
      compare_value_b_reg <= CMP_RESET;
    end else begin
      if (wr_cmpa_lo) begin
        compare_value_a_reg <= {byte_staging_latch_reg, bus_wdata};
      end
      if (wr_cmpb_lo) begin
        compare_value_b_reg <= {byte_staging_latch_reg, bus_wdata};
      end
    end
  end

  // Capture register, loaded on every strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      capture_value_reg <= CAP_RESET;
    end else if (cap_strobe) begin
      capture_value_reg <= free_running_counter_reg;
    end
  end

  // Staging latch shared by all 16-bit registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      byte_staging_latch_reg <= 8'h00;
    end else if (bus_wr && (hit(bus_addr, ADDR_CNT_HI) ||
                 hit(bus_addr, ADDR_CMPA_HI) ||
                 hit(bus_addr, ADDR_CMPB_HI))) begin
      byte_staging_latch_reg <= bus_wdata;
    end else if (bus_rd && hit(bus_addr, ADDR_CNT_HI)) begin
      byte_staging_latch_reg <= free_running_counter_reg[7:0];
    end else if (cap_hi_read) begin
      byte_staging_latch_reg <= capture_value_reg[7:0];
    end
  end

  // Control register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      timer_control_reg <= CTRL_RESET;
    end else if (bus_wr && hit(bus_addr, ADDR_CTRL)) begin
      timer_control_reg <= bus_wdata;
    end
  end

  assign flag_set = {cap_strobe, match_b, match_a, wrap_ev};

  // Flags: set wins over clear; a 0 write clears only a flag read as 1
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      timer_ctrl_status_reg <= STAT_RESET;
      flag_seen_reg <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (flag_set[i]) begin
          timer_ctrl_status_reg[STAT_WRAP_F + i] <= 1'b1;
        end else if (stat_wr && !bus_wdata[STAT_WRAP_F + i] &&
                     flag_seen_reg[i]) begin
          timer_ctrl_status_reg[STAT_WRAP_F + i] <= 1'b0;
        end
        if (stat_wr) begin
          flag_seen_reg[i] <= 1'b0;
        end else if (stat_rd && timer_ctrl_status_reg[STAT_WRAP_F + i]) begin
          flag_seen_reg[i] <= 1'b1;
        end
      end
      if (stat_wr) begin
        timer_ctrl_status_reg[3:0] <= bus_wdata[3:0];
      end
    end
  end

  // Compare pins hold 0 until their first enabled match
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_a_reg <= 1'b0;
      pin_b_reg <= 1'b0;
    end else begin
      if (match_a && timer_control_reg[CTRL_PINA_EN]) begin
        pin_a_reg <= timer_ctrl_status_reg[STAT_LVL_A];
      end
      if (match_b && timer_control_reg[CTRL_PINB_EN]) begin
        pin_b_reg <= timer_ctrl_status_reg[STAT_LVL_B];
      end
    end
  end

  assign compare_pin_a = pin_a_reg;
  assign compare_pin_b = pin_b_reg;

  // Read data, registered one cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else if (bus_rd) begin
      if (hit(bus_addr, ADDR_CTRL)) begin
        rdata_reg <= timer_control_reg;
      end else if (hit(bus_addr, ADDR_STAT)) begin
        rdata_reg <= timer_ctrl_status_reg;
      end else if (hit(bus_addr, ADDR_CNT_HI)) begin
        rdata_reg <= free_running_counter_reg[15:8];
      end else if (hit(bus_addr, ADDR_CMPA_HI)) begin
        rdata_reg <= compare_value_a_reg[15:8];
      end else if (hit(bus_addr, ADDR_CMPA_LO)) begin
        rdata_reg <= compare_value_a_reg[7:0];
      end else if (hit(bus_addr, ADDR_CMPB_HI)) begin
        rdata_reg <= compare_value_b_reg[15:8];
      end else if (hit(bus_addr, ADDR_CMPB_LO)) begin
        rdata_reg <= compare_value_b_reg[7:0];
      end else if (hit(bus_addr, ADDR_CAP_HI)) begin
        rdata_reg <= capture_value_reg[15:8];
      end else if (hit(bus_addr, ADDR_CNT_LO) ||
                   hit(bus_addr, ADDR_CAP_LO)) begin
        rdata_reg <= byte_staging_latch_reg;
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  assign bus_rdata = rdata_reg;

  // Interrupt requests and their fixed priority
  assign capture_irq = timer_ctrl_status_reg[STAT_CAP_F] &&
                       timer_control_reg[CTRL_CAP_IE];
  assign compare_a_irq = timer_ctrl_status_reg[STAT_CMPA_F] &&
                         timer_control_reg[CTRL_CMPA_IE];
  assign compare_b_irq = timer_ctrl_status_reg[STAT_CMPB_F] &&
                         timer_control_reg[CTRL_CMPB_IE];
  assign wrap_irq = timer_ctrl_status_reg[STAT_WRAP_F] &&
                    timer_control_reg[CTRL_WRAP_IE];

  always_comb begin
    if (capture_irq) begin
      irq_top_code = 3'h4;
    end else if (compare_a_irq) begin
      irq_top_code = 3'h3;
    end else if (compare_b_irq) begin
      irq_top_code = 3'h2;
    end else if (wrap_irq) begin
      irq_top_code = 3'h1;
    end else begin
      irq_top_code = 3'h0;
    end
  end
endmodule
`default_nettype wire

// [frt_timer_checker.sv]
// Checker for the timer's interrupt, priority and compare pin behaviour.
// Assumes it is bound to frt_timer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module frt_timer_checker
  import frt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic compare_pin_a,
  input wire logic compare_pin_b,
  input wire logic capture_irq,
  input wire logic compare_a_irq,
  input wire logic compare_b_irq,
  input wire logic wrap_irq,
  input wire logic [2:0] irq_top_code
);
  logic [7:0] ctl_reg;
  logic [3:0] lvl_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Shadow of the control register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) ctl_reg <= 8'h00;
    else if (bus_wr && bus_addr == ADDR_CTRL) ctl_reg <= bus_wdata;
  end
  // Shadow of the level bits
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) lvl_reg <= 4'h0;
    else if (bus_wr && bus_addr == ADDR_STAT) lvl_reg <= bus_wdata[3:0];
  end
  sequence s_no_read;
    !bus_rd [*2];
  endsequence
  sequence s_moves_a;
    $changed(compare_pin_a);
  endsequence
  sequence s_moves_b;
    $changed(compare_pin_b);
  endsequence
  property p_after_reset;
    $rose(rstn) |-> !compare_pin_a && !compare_pin_b && irq_top_code == 3'h0;
  endproperty
  property p_cap_gate;
    capture_irq |-> ctl_reg[CTRL_CAP_IE];
  endproperty
  property p_low_gate;
    ({compare_b_irq, compare_a_irq, wrap_irq} & ~ctl_reg[6:4]) == 3'h0;
  endproperty
  property p_pri_cap;
    capture_irq |-> irq_top_code == 3'h4;
  endproperty
  property p_pri_a;
    !capture_irq && compare_a_irq |-> irq_top_code == 3'h3;
  endproperty
  property p_pri_low;
    !capture_irq && !compare_a_irq |->
      irq_top_code == (compare_b_irq ? 3'h2 : wrap_irq ? 3'h1 : 3'h0);
  endproperty
  property p_pin_a_en;
    s_moves_a |-> $past(ctl_reg[CTRL_PINA_EN]);
  endproperty
  property p_pin_b_en;
    s_moves_b |-> $past(ctl_reg[CTRL_PINB_EN]);
  endproperty
  property p_pin_a_lvl;
    s_moves_a |-> compare_pin_a == $past(lvl_reg[STAT_LVL_A]);
  endproperty
  property p_pin_b_lvl;
    s_moves_b |-> compare_pin_b == $past(lvl_reg[STAT_LVL_B]);
  endproperty
  property p_rdata_hold;
    s_no_read |-> $stable(bus_rdata);
  endproperty
  a_after_reset: assert property (p_after_reset)
    else $error("compare pins or irqs not idle after reset");
  a_cap_gate: assert property (p_cap_gate)
    else $error("capture irq while disabled");
  a_low_gate: assert property (p_low_gate)
    else $error("compare or wrap irq while disabled");
  a_pri_cap: assert property (p_pri_cap)
    else $error("capture irq not top priority");
  a_pri_a: assert property (p_pri_a)
    else $error("compare A irq not second priority");
  a_pri_low: assert property (p_pri_low)
    else $error("low priority code wrong");
  a_pin_a_en: assert property (p_pin_a_en)
    else $error("compare pin A moved while disabled");
  a_pin_b_en: assert property (p_pin_b_en)
    else $error("compare pin B moved while disabled");
  a_pin_a_lvl: assert property (p_pin_a_lvl)
    else $error("compare pin A took wrong level");
  a_pin_b_lvl: assert property (p_pin_b_lvl)
    else $error("compare pin B took wrong level");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");
endmodule
bind frt_timer frt_timer_checker frt_timer_checker_i (.sys_clk, .rstn,
  .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata, .compare_pin_a,
  .compare_pin_b, .capture_irq, .compare_a_irq, .compare_b_irq, .wrap_irq,
  .irq_top_code);
`default_nettype wire

// [frt_cpu_model.sv]
// CPU byte bus model for the timer's register port.
// Assumes strobes taken at the rising edge, read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module frt_cpu_model (
  input wire logic sys_clk,
  output var logic [15:0] bus_addr,
  output var logic bus_rd,
  output var logic bus_wr,
  output var logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata
);
  int slow;
  initial begin
    slow = 0;
    bus_addr = 16'h0000;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 8'h00;
  end
  // One byte access; a released bus shows inverted values
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    repeat (slow) @(negedge sys_clk);
    @(negedge sys_clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = w;
    bus_rd = !w;
    @(negedge sys_clk);
    q = bus_rdata;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask
  // Word access: upper byte, then lower byte, nothing between
  task automatic acc16(input logic w, input logic [15:0] a,
                       input logic [15:0] d, output logic [15:0] q);
    acc(w, a, d[15:8], q[15:8]);
    acc(w, a + 16'h0001, d[7:0], q[7:0]);
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the capture/compare timer.
// Assumes the bound checker and the CPU bus model beside the timer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import frt_pkg::*;
  logic sys_clk, rstn, ext_pin, cap_pin, rd_taken;
  logic bus_rd, bus_wr, pin_a, pin_b, cap_irq, a_irq, b_irq, w_irq;
  logic [15:0] bus_addr, q16, v;
  logic [7:0] bus_wdata, bus_rdata, seed;
  logic [8:0] note;
  logic [2:0] code;
  logic [8:0] exp_q[$];
  int fails, compares;
  frt_timer frt_timer_i (.sys_clk, .rstn, .bus_addr, .bus_rd, .bus_wr,
    .bus_wdata, .bus_rdata, .external_count_clock_pin(ext_pin),
    .capture_input_pin(cap_pin), .compare_pin_a(pin_a),
    .compare_pin_b(pin_b), .capture_irq(cap_irq), .compare_a_irq(a_irq),
    .compare_b_irq(b_irq), .wrap_irq(w_irq), .irq_top_code(code));
  frt_cpu_model frt_cpu_model_i (.sys_clk, .bus_addr, .bus_rd, .bus_wr,
    .bus_wdata, .bus_rdata);
  always #20 sys_clk = ~sys_clk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic check_near(input logic [15:0] g, input int lo,
                            input int hi);
    compares++;
    if ((^g === 1'bx) || g < lo || g > hi) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h..%h", $time, g, lo, hi);
    end
  endtask
  task automatic report_and_stop();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    frt_cpu_model_i.acc(1'b1, a, d, q);
  endtask
  task automatic wr16(input logic [15:0] a, input logic [15:0] d);
    frt_cpu_model_i.acc16(1'b1, a, d, q16);
  endtask
  task automatic rd8(input logic [15:0] a, input logic [7:0] e,
                     input logic chk = 1'b1);
    logic [7:0] q;
    exp_q.push_back({chk, e});
    frt_cpu_model_i.acc(1'b0, a, 8'h00, q);
  endtask
  task automatic rd16(input logic [15:0] a, input logic [15:0] e,
                      input logic chk = 1'b1);
    exp_q.push_back({chk, e[15:8]});
    exp_q.push_back({chk, e[7:0]});
    frt_cpu_model_i.acc16(1'b0, a, 16'h0000, q16);
  endtask
  // External clock levels held three cycles each
  task automatic pulse(input int n);
    repeat (n) begin
      ext_pin = 1'b1;
      repeat (3) @(negedge sys_clk);
      ext_pin = 1'b0;
      repeat (3) @(negedge sys_clk);
    end
  endtask
  task automatic cap_to(input logic val);
    cap_pin = val;
    repeat (8) @(negedge sys_clk);
  endtask
  // Read results checked against the oldest note
  always @(posedge sys_clk) rd_taken <= bus_rd;
  always @(negedge sys_clk) begin
    if (rd_taken && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[8]) check(bus_rdata, note[7:0]);
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    report_and_stop();
  end
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    ext_pin = 1'b0;
    cap_pin = 1'b1;
    seed = 8'h0C;
    repeat (12) @(negedge sys_clk);
    rstn = 1'b1;
    rd8(ADDR_CTRL, CTRL_RESET);
    rd8(ADDR_STAT, STAT_RESET);
    rd16(ADDR_CMPA_HI, CMP_RESET);
    rd16(ADDR_CMPB_HI, CMP_RESET);
    rd16(ADDR_CAP_HI, CAP_RESET);
    rd8(16'hFF9A, 8'h00);
    seed = lfsr(seed);
    wr8(ADDR_CTRL, seed);
    rd8(ADDR_CTRL, seed);
    for (int k = 0; k < 3; k++) begin
      wr8(ADDR_CTRL, {6'h00, CKS_EXT});
      wr16(ADDR_CNT_HI, CNT_RESET);
      wr8(ADDR_CTRL, {6'h00, k[1:0]});
      repeat (64) @(negedge sys_clk);
      wr8(ADDR_CTRL, {6'h00, CKS_EXT});
      rd16(ADDR_CNT_HI, CNT_RESET, 1'b0);
      check_near(q16, (64 >> (2*k+1)) - 1, (68 >> (2*k+1)) + 1);
    end
    seed = lfsr(seed);
    v = {1'b1, seed[6:0], lfsr(seed)};
    wr16(ADDR_CNT_HI, v);
    rd16(ADDR_CNT_HI, v);
    pulse(5);
    rd16(ADDR_CNT_HI, v + 16'h0005);
    wr16(ADDR_CMPA_HI, 16'h0010);
    rd16(ADDR_CMPA_HI, 16'h0010);
    frt_cpu_model_i.slow = 1;
    wr16(ADDR_CNT_HI, 16'hFFFE);
    rd8(ADDR_STAT, 8'h00, 1'b0);
    wr8(ADDR_STAT, 8'h08);
    wr8(ADDR_CTRL, 8'h1B);
    pulse(2);
    rd8(ADDR_STAT, 8'h58);
    check({7'h00, pin_b}, 8'h01);
    check({7'h00, w_irq}, 8'h01);
    check({5'h00, code}, 8'h01);
    wr8(ADDR_STAT, 8'hF0);
    rd8(ADDR_STAT, 8'h50);
    wr8(ADDR_STAT, 8'h04);
    rd8(ADDR_STAT, 8'h04);
    wr16(ADDR_CMPB_HI, 16'h0010);
    wr8(ADDR_CTRL, 8'h77);
    pulse(16);
    check({7'h00, pin_a}, 8'h01);
    check({7'h00, pin_b}, 8'h01);
    check({5'h00, code}, 8'h03);
    check({6'h00, a_irq, b_irq}, 8'h03);
    rd8(ADDR_STAT, 8'h64);
    wr8(ADDR_STAT, 8'h01);
    rd16(ADDR_CNT_HI, 16'h0000);
    check({7'h00, pin_a}, 8'h00);
    rd8(ADDR_STAT, 8'h61);
    wr8(ADDR_STAT, 8'h00);
    wr8(ADDR_CTRL, 8'h83);
    wr16(ADDR_CNT_HI, 16'h1234);
    cap_to(1'b0);
    check({5'h00, code}, 8'h04);
    check({7'h00, cap_irq}, 8'h01);
    rd16(ADDR_CAP_HI, 16'h1234);
    wr16(ADDR_CNT_HI, 16'h4321);
    cap_to(1'b1);
    rd16(ADDR_CAP_HI, 16'h1234);
    cap_to(1'b0);
    rd16(ADDR_CAP_HI, 16'h4321);
    rd8(ADDR_STAT, 8'h80);
    wr8(ADDR_STAT, 8'h02);
    wr16(ADDR_CNT_HI, 16'h5AA5);
    cap_to(1'b1);
    rd16(ADDR_CAP_HI, 16'h5AA5);
    report_and_stop();
  end
endmodule
`default_nettype wire
